/* rtl/accp_pkg.sv */
// package: register map, field positions, reset values and carrier types
package accp_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] ACCP_OFS_POWER_READY = 8'h00;
  localparam logic [7:0] ACCP_OFS_CALIBRATION = 8'h04;
  localparam logic [7:0] ACCP_OFS_IRQ_STATUS  = 8'h08;
  localparam logic [7:0] ACCP_OFS_IRQ_ENABLE  = 8'h0C;
  localparam logic [7:0] ACCP_OFS_IRQ_CLEAR   = 8'h10;

  // ----------------------------------------------------------------
  // power/ready register fields
  // ----------------------------------------------------------------
  localparam int ACCP_BIT_SHARED_READY = 15;
  localparam int ACCP_BIT_CORE1_READY  = 9;
  localparam int ACCP_BIT_CORE0_READY  = 8;
  localparam int ACCP_BIT_SHARED_PWR   = 7;
  localparam int ACCP_BIT_CORE1_PWR    = 1;
  localparam int ACCP_BIT_CORE0_PWR    = 0;

  // ----------------------------------------------------------------
  // calibration register fields; core 1 sits this far above core 0
  // ----------------------------------------------------------------
  localparam int ACCP_CAL_CORE_STRIDE = 8;
  localparam int ACCP_BIT_CAL_DONE    = 7;
  localparam int ACCP_BIT_CAL_BYPASS  = 3;
  localparam int ACCP_BIT_CAL_MODE    = 2;
  localparam int ACCP_BIT_CAL_ENABLE  = 1;
  localparam int ACCP_BIT_CAL_START   = 0;

  // ----------------------------------------------------------------
  // interrupt status bits
  // ----------------------------------------------------------------
  localparam int ACCP_IRQ_WIDTH       = 5;
  localparam int ACCP_IRQ_SHARED_RDY  = 0;
  localparam int ACCP_IRQ_CORE0_RDY   = 1;
  localparam int ACCP_IRQ_CORE1_RDY   = 2;
  localparam int ACCP_IRQ_CORE0_CAL   = 3;
  localparam int ACCP_IRQ_CORE1_CAL   = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] ACCP_RST_REG16 = 16'h0000;
  localparam logic [31:0] ACCP_RST_RDATA = 32'h0000_0000;

  // ----------------------------------------------------------------
  // carrier to and from one dedicated core's calibration engine
  // ----------------------------------------------------------------
  typedef struct packed {
    logic power;
    logic ready;
    logic bypass;
    logic mode;
    logic start;
  } accp_cal_req_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic cal_go;
    logic cal_diff;
  } accp_cal_rsp_t;

endpackage : accp_pkg

/* rtl/accp_irq.sv */
// sticky interrupt status with enable and write-one-to-clear
`timescale 1ns/1ps
`default_nettype none
module accp_irq
  import accp_pkg::*;
#(
  parameter int WIDTH = ACCP_IRQ_WIDTH
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] event_set,
  input  wire logic             enable_we,
  input  wire logic             clear_we,
  input  wire logic [WIDTH-1:0] wdata,
  output logic      [WIDTH-1:0] status,
  output logic      [WIDTH-1:0] enable,
  output logic                  irq
);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable <= '0;
    end else if (enable_we) begin
      enable <= wdata;
    end
  end

  // a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
    end else begin
      status <= (status & ~(clear_we ? wdata : '0)) | event_set;
    end
  end

  assign irq = |(status & enable);

  chk_irq_sticky_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (status[0] && !clear_we) |=> status[0])
    else $error("status bit dropped without a clear");

endmodule : accp_irq
`default_nettype wire

/* rtl/accp_cal_engine.sv */
// calibration sequencer for one dedicated converter core
`timescale 1ns/1ps
`default_nettype none
module accp_cal_engine
  import accp_pkg::*;
#(
  parameter int CAL_CYCLES = 16
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire accp_cal_req_t req,
  output accp_cal_rsp_t      rsp
);

  typedef enum logic [1:0] {
    ACCP_CAL_IDLE,
    ACCP_CAL_RUN
  } accp_cal_state_t;

  accp_cal_state_t state;
  logic [15:0]     count;
  logic            done;
  logic            diff;
  logic            ready_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= req.ready;
    end
  end

  // power-up calibration unless bypassed, or software start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ACCP_CAL_IDLE;
      count <= '0;
      done  <= 1'b0;
      diff  <= 1'b0;
    end else begin
      case (state)
        ACCP_CAL_IDLE: begin
          if (req.power && (req.start ||
              (req.ready && !ready_q && !req.bypass))) begin
            state <= ACCP_CAL_RUN;
            count <= 16'(CAL_CYCLES - 1);
            done  <= 1'b0;
            diff  <= req.mode;
          end
        end
        ACCP_CAL_RUN: begin
          if (!req.power) begin
            state <= ACCP_CAL_IDLE;
          end else if (count == '0) begin
            state <= ACCP_CAL_IDLE;
            done  <= 1'b1;
          end else begin
            count <= count - 16'h0001;
          end
        end
        default: state <= ACCP_CAL_IDLE;
      endcase
    end
  end

  assign rsp.busy     = (state == ACCP_CAL_RUN);
  assign rsp.done     = done;
  assign rsp.cal_go   = (state == ACCP_CAL_RUN);
  assign rsp.cal_diff = diff;

endmodule : accp_cal_engine
`default_nettype wire

/* rtl/accp_ctrl.sv */
// converter core power and calibration control with APB register access
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module accp_ctrl
  import accp_pkg::*;
#(
  parameter int CAL_CYCLES = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        shared_core_ready,
  input  wire logic        dedicated_core1_ready,
  input  wire logic        dedicated_core0_ready,
  output logic             shared_core_power,
  output logic             dedicated_core1_power,
  output logic             dedicated_core0_power,
  output logic [1:0]       core_cal_run,
  output logic [1:0]       core_cal_diff,
  output logic             irq
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic        wr_en;
  logic        rd_en;
  logic        hit;
  logic        wr_pwr;
  logic        wr_cal;
  logic        wr_ien;
  logic        wr_iclr;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  always_comb begin
    hit = 1'b1;
    if (paddr == ACCP_OFS_POWER_READY) begin
      hit = 1'b1;
    end else if (paddr == ACCP_OFS_CALIBRATION) begin
      hit = 1'b1;
    end else if (paddr == ACCP_OFS_IRQ_STATUS) begin
      hit = 1'b1;
    end else if (paddr == ACCP_OFS_IRQ_ENABLE) begin
      hit = 1'b1;
    end else if (paddr == ACCP_OFS_IRQ_CLEAR) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end

  assign wr_pwr  = wr_en && (paddr == ACCP_OFS_POWER_READY);
  assign wr_cal  = wr_en && (paddr == ACCP_OFS_CALIBRATION);
  assign wr_ien  = wr_en && (paddr == ACCP_OFS_IRQ_ENABLE);
  assign wr_iclr = wr_en && (paddr == ACCP_OFS_IRQ_CLEAR);

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  // ----------------------------------------------------------------
  // power enables
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shared_core_power     <= 1'b0;
      dedicated_core1_power <= 1'b0;
      dedicated_core0_power <= 1'b0;
    end else if (wr_pwr) begin
      shared_core_power     <= pwdata[ACCP_BIT_SHARED_PWR];
      dedicated_core1_power <= pwdata[ACCP_BIT_CORE1_PWR];
      dedicated_core0_power <= pwdata[ACCP_BIT_CORE0_PWR];
    end
  end

  // ready flags only while powered
  logic shared_core_ready_flag;
  logic dedicated_core1_ready_flag;
  logic dedicated_core0_ready_flag;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shared_core_ready_flag     <= 1'b0;
      dedicated_core1_ready_flag <= 1'b0;
      dedicated_core0_ready_flag <= 1'b0;
    end else begin
      shared_core_ready_flag     <= shared_core_power &&
                                    shared_core_ready;
      dedicated_core1_ready_flag <= dedicated_core1_power &&
                                    dedicated_core1_ready;
      dedicated_core0_ready_flag <= dedicated_core0_power &&
                                    dedicated_core0_ready;
    end
  end

  // ----------------------------------------------------------------
  // calibration controls, one slice per dedicated core
  // ----------------------------------------------------------------
  logic [1:0]    cal_access_enable;
  logic [1:0]    cal_bypass;
  logic [1:0]    cal_mode;
  logic [1:0]    cal_start;
  logic [1:0]    core_power;
  logic [1:0]    core_ready;
  accp_cal_req_t cal_req [2];
  accp_cal_rsp_t cal_rsp [2];
  logic [1:0]    cal_done_q;

  assign core_power = {dedicated_core1_power, dedicated_core0_power};
  assign core_ready = {dedicated_core1_ready_flag,
                       dedicated_core0_ready_flag};

  function automatic int cal_bit(input int core, input int field);
    cal_bit = core * ACCP_CAL_CORE_STRIDE + field;
  endfunction : cal_bit

  for (genvar c = 0; c < 2; c++) begin : g_core
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cal_access_enable[c] <= 1'b0;
      end else if (wr_cal) begin
        cal_access_enable[c] <= pwdata[cal_bit(c, ACCP_BIT_CAL_ENABLE)];
      end
    end

    // other fields take writes only when access is open
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cal_bypass[c] <= 1'b0;
        cal_mode[c]   <= 1'b0;
      end else if (wr_cal && cal_access_enable[c]) begin
        cal_bypass[c] <= pwdata[cal_bit(c, ACCP_BIT_CAL_BYPASS)];
        cal_mode[c]   <= pwdata[cal_bit(c, ACCP_BIT_CAL_MODE)];
      end
    end

    // start holds until the engine takes it or the core loses power, then clears
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cal_start[c] <= 1'b0;
      end else if (cal_start[c] && (cal_rsp[c].busy || !core_power[c])) begin
        cal_start[c] <= 1'b0;
      end else if (wr_cal && cal_access_enable[c] &&
                   pwdata[cal_bit(c, ACCP_BIT_CAL_START)]) begin
        cal_start[c] <= 1'b1;
      end
    end

    assign cal_req[c].power  = core_power[c];
    assign cal_req[c].ready  = core_ready[c];
    assign cal_req[c].bypass = cal_bypass[c];
    assign cal_req[c].mode   = cal_mode[c];
    assign cal_req[c].start  = cal_start[c] && !cal_rsp[c].busy;

    accp_cal_engine #(
      .CAL_CYCLES (CAL_CYCLES)
    ) u_cal (
      .pclk    (pclk),
      .presetn (presetn),
      .req     (cal_req[c]),
      .rsp     (cal_rsp[c])
    );

    assign core_cal_run[c]  = cal_rsp[c].cal_go;
    assign core_cal_diff[c] = cal_rsp[c].cal_diff;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cal_done_q[c] <= 1'b0;
      end else begin
        cal_done_q[c] <= cal_rsp[c].done;
      end
    end

    chk_start_self_clear: assert property (@(posedge pclk)
      disable iff (!presetn)
      cal_start[c] |-> ##[1:3] !cal_start[c])
      else $error("calibration start bit did not clear");

    chk_done_while_busy: assert property (@(posedge pclk)
      disable iff (!presetn)
      cal_rsp[c].busy |-> !cal_rsp[c].done)
      else $error("done flag high while calibrating");

    chk_bypass_skips_cal: assert property (@(posedge pclk)
      disable iff (!presetn)
      (cal_bypass[c] && !cal_start[c] && !cal_rsp[c].busy)
        |=> !cal_rsp[c].busy)
      else $error("bypassed core calibrated after power-up");

    chk_mode_drives_diff: assert property (@(posedge pclk)
      disable iff (!presetn)
      $rose(cal_rsp[c].busy) |->
        (cal_rsp[c].cal_diff == $past(cal_mode[c])))
      else $error("calibration input mode mismatch");
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  logic [ACCP_IRQ_WIDTH-1:0] irq_event;
  logic [ACCP_IRQ_WIDTH-1:0] irq_status;
  logic [ACCP_IRQ_WIDTH-1:0] irq_enable;
  logic                      shared_rdy_q;
  logic [1:0]                core_rdy_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shared_rdy_q <= 1'b0;
      core_rdy_q   <= 2'b00;
    end else begin
      shared_rdy_q <= shared_core_ready_flag;
      core_rdy_q   <= core_ready;
    end
  end

  always_comb begin
    irq_event = '0;
    irq_event[ACCP_IRQ_SHARED_RDY] = shared_core_ready_flag && !shared_rdy_q;
    irq_event[ACCP_IRQ_CORE0_RDY]  = core_ready[0] && !core_rdy_q[0];
    irq_event[ACCP_IRQ_CORE1_RDY]  = core_ready[1] && !core_rdy_q[1];
    irq_event[ACCP_IRQ_CORE0_CAL]  = cal_rsp[0].done && !cal_done_q[0];
    irq_event[ACCP_IRQ_CORE1_CAL]  = cal_rsp[1].done && !cal_done_q[1];
  end

  accp_irq #(
    .WIDTH (ACCP_IRQ_WIDTH)
  ) u_irq (
    .pclk      (pclk),
    .presetn   (presetn),
    .event_set (irq_event),
    .enable_we (wr_ien),
    .clear_we  (wr_iclr),
    .wdata     (pwdata[ACCP_IRQ_WIDTH-1:0]),
    .status    (irq_status),
    .enable    (irq_enable),
    .irq       (irq)
  );

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  logic [15:0] pwr_word;
  logic [15:0] cal_word;
  logic [31:0] next_rdata;

  always_comb begin
    pwr_word = ACCP_RST_REG16;
    pwr_word[ACCP_BIT_SHARED_READY] = shared_core_ready_flag;
    pwr_word[ACCP_BIT_CORE1_READY]  = dedicated_core1_ready_flag;
    pwr_word[ACCP_BIT_CORE0_READY]  = dedicated_core0_ready_flag;
    pwr_word[ACCP_BIT_SHARED_PWR]   = shared_core_power;
    pwr_word[ACCP_BIT_CORE1_PWR]    = dedicated_core1_power;
    pwr_word[ACCP_BIT_CORE0_PWR]    = dedicated_core0_power;
    cal_word = ACCP_RST_REG16;
    for (int c = 0; c < 2; c++) begin
      cal_word[cal_bit(c, ACCP_BIT_CAL_ENABLE)] = cal_access_enable[c];
      if (cal_access_enable[c]) begin
        cal_word[cal_bit(c, ACCP_BIT_CAL_DONE)]   = cal_rsp[c].done;
        cal_word[cal_bit(c, ACCP_BIT_CAL_BYPASS)] = cal_bypass[c];
        cal_word[cal_bit(c, ACCP_BIT_CAL_MODE)]   = cal_mode[c];
        cal_word[cal_bit(c, ACCP_BIT_CAL_START)]  = cal_start[c];
      end
    end
  end

  always_comb begin
    next_rdata = ACCP_RST_RDATA;
    if (paddr == ACCP_OFS_POWER_READY) begin
      next_rdata = {16'h0000, pwr_word};
    end else if (paddr == ACCP_OFS_CALIBRATION) begin
      next_rdata = {16'h0000, cal_word};
    end else if (paddr == ACCP_OFS_IRQ_STATUS) begin
      next_rdata = {{(32-ACCP_IRQ_WIDTH){1'b0}}, irq_status};
    end else if (paddr == ACCP_OFS_IRQ_ENABLE) begin
      next_rdata = {{(32-ACCP_IRQ_WIDTH){1'b0}}, irq_enable};
    end else begin
      next_rdata = ACCP_RST_RDATA;
    end
  end

  // data registered at setup so it is stable in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= ACCP_RST_RDATA;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_shared_power_write: assert property (@(posedge pclk)
    disable iff (!presetn)
    wr_pwr |=> shared_core_power == $past(pwdata[ACCP_BIT_SHARED_PWR]))
    else $error("shared core power does not follow write");

  chk_core_power_write: assert property (@(posedge pclk)
    disable iff (!presetn)
    wr_pwr |=> dedicated_core0_power == $past(pwdata[ACCP_BIT_CORE0_PWR]))
    else $error("core 0 power does not follow write");

  chk_shared_ready_off: assert property (@(posedge pclk)
    disable iff (!presetn)
    !shared_core_power |=> !shared_core_ready_flag)
    else $error("shared ready set while unpowered");

  chk_core_ready_flag: assert property (@(posedge pclk)
    disable iff (!presetn)
    dedicated_core1_ready_flag |-> $past(dedicated_core1_power))
    else $error("core 1 ready set while unpowered");

  chk_locked_cal_read: assert property (@(posedge pclk)
    disable iff (!presetn)
    !cal_access_enable[0] |-> cal_word[7:2] == 6'h00 && !cal_word[0])
    else $error("locked calibration bits visible");

  chk_reserved_zero: assert property (@(posedge pclk)
    disable iff (!presetn)
    pwr_word[14:10] == 5'h00 && pwr_word[6:2] == 5'h00)
    else $error("reserved bits read nonzero");

endmodule : accp_ctrl
`default_nettype wire

/* bench/accp_core_model.sv */
// behavioural analog cores: ready follows power after a settling delay
`timescale 1ns/1ps
`default_nettype none
module accp_core_model #(
  parameter int READY_DLY = 3
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [2:0] power,
  output logic      [2:0] ready
);
  int cnt [3];
  // ready drops at once when power goes away, rises only after settling
  always_ff @(posedge pclk or negedge presetn) begin
    for (int i = 0; i < 3; i++) begin
      if (!presetn || !power[i]) begin
        cnt[i]   <= 0;
        ready[i] <= 1'b0;
      end else if (cnt[i] < READY_DLY) begin
        cnt[i] <= cnt[i] + 1;
      end else begin
        ready[i] <= 1'b1;
      end
    end
  end
endmodule : accp_core_model
`default_nettype wire

/* bench/tb.sv */
// self-checking bench for converter core power and calibration control
`timescale 1ns/1ps
`default_nettype none
module tb
  import accp_pkg::*;
;
  localparam int CAL_N = 4;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic        irq;
  logic [2:0]  pwr;
  logic [2:0]  rdy;
  logic [1:0]  run;
  logic [1:0]  diff;
  int          n_errors;
  int          n_tests;
  int          cyc;

  accp_ctrl #(.CAL_CYCLES(CAL_N)) accp_ctrl_inst (
    .pclk                  (pclk),
    .presetn               (presetn),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .shared_core_ready     (rdy[2]),
    .dedicated_core1_ready (rdy[1]),
    .dedicated_core0_ready (rdy[0]),
    .shared_core_power     (pwr[2]),
    .dedicated_core1_power (pwr[1]),
    .dedicated_core0_power (pwr[0]),
    .core_cal_run          (run),
    .core_cal_diff         (diff),
    .irq                   (irq)
  );

  accp_core_model accp_core_model_inst (
    .pclk    (pclk),
    .presetn (presetn),
    .power   (pwr),
    .ready   (rdy)
  );

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task close_out;
    $display("errors %0d comparisons %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rdchk

  // waits a bounded time for one core's run line to reach a level
  task wait_run(input int c, input logic lvl);
    repeat (40) begin
      if (run[c] !== lvl) @(posedge pclk);
    end
    chk({31'h0, run[c]}, {31'h0, lvl});
  endtask : wait_run

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset;
    for (int i = 0; i < 5; i++) rdchk(8'(4 * i), 32'h0000_0000);
    rdchk(8'h14, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    chk({29'h0, pwr}, 32'h0000_0000);
    chk({31'h0, pready}, 32'h0000_0001);
  endtask : t_reset

  task t_power;
    // enable opens access first; bypass is written by the next word
    apb(1'b1, ACCP_OFS_CALIBRATION, 32'h0000_0202);
    apb(1'b1, ACCP_OFS_CALIBRATION, 32'h0000_0A0A);
    apb(1'b1, ACCP_OFS_POWER_READY, 32'hFFFF_FFFF);
    @(posedge pclk);
    chk({29'h0, pwr}, 32'h0000_0007);
    repeat (10) @(posedge pclk);
    chk({30'h0, run}, 32'h0000_0000);
    rdchk(ACCP_OFS_POWER_READY, 32'h0000_8383);
    apb(1'b1, ACCP_OFS_POWER_READY, 32'h0000_0002);
    @(posedge pclk);
    chk({29'h0, pwr}, 32'h0000_0002);
    rdchk(ACCP_OFS_POWER_READY, 32'h0000_0202);
    apb(1'b1, ACCP_OFS_POWER_READY, 32'h0000_0083);
    repeat (10) @(posedge pclk);
    rdchk(ACCP_OFS_POWER_READY, 32'h0000_8383);
  endtask : t_power

  task t_cal_start;
    apb(1'b1, ACCP_OFS_CALIBRATION, 32'h0000_0A07);
    wait_run(0, 1'b1);
    chk({31'h0, diff[0]}, 32'h0000_0001);
    rdchk(ACCP_OFS_CALIBRATION, 32'h0000_0A06);
    wait_run(0, 1'b0);
    rdchk(ACCP_OFS_CALIBRATION, 32'h0000_0A86);
    apb(1'b1, ACCP_OFS_CALIBRATION, 32'h0000_0A03);
    wait_run(0, 1'b1);
    chk({31'h0, diff[0]}, 32'h0000_0000);
    wait_run(0, 1'b0);
  endtask : t_cal_start

  task t_powerup_cal;
    apb(1'b1, ACCP_OFS_CALIBRATION, 32'h0000_0202);
    apb(1'b1, ACCP_OFS_POWER_READY, 32'h0000_0081);
    repeat (4) @(posedge pclk);
    apb(1'b1, ACCP_OFS_POWER_READY, 32'h0000_0083);
    wait_run(1, 1'b1);
    chk({31'h0, diff[1]}, 32'h0000_0000);
    wait_run(1, 1'b0);
    rdchk(ACCP_OFS_CALIBRATION, 32'h0000_8282);
  endtask : t_powerup_cal

  task t_lock;
    // close access first; the locked word must then be ignored
    apb(1'b1, ACCP_OFS_CALIBRATION, 32'h0000_0000);
    apb(1'b1, ACCP_OFS_CALIBRATION, 32'h0000_0D0D);
    repeat (4) @(posedge pclk);
    chk({30'h0, run}, 32'h0000_0000);
    rdchk(ACCP_OFS_CALIBRATION, 32'h0000_0000);
    apb(1'b1, ACCP_OFS_CALIBRATION, 32'h0000_0202);
    rdchk(ACCP_OFS_CALIBRATION, 32'h0000_8282);
  endtask : t_lock

  task t_irq;
    rdchk(ACCP_OFS_IRQ_STATUS, 32'h0000_001F);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(1'b1, ACCP_OFS_IRQ_ENABLE, 32'h0000_0001);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0001);
    apb(1'b1, ACCP_OFS_IRQ_CLEAR, 32'h0000_0001);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0000);
    rdchk(ACCP_OFS_IRQ_STATUS, 32'h0000_001E);
    apb(1'b1, ACCP_OFS_IRQ_ENABLE, 32'h0000_001F);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0001);
    rdchk(ACCP_OFS_IRQ_ENABLE, 32'h0000_001F);
    apb(1'b1, ACCP_OFS_IRQ_CLEAR, 32'h0000_001F);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0000);
    rdchk(ACCP_OFS_IRQ_CLEAR, 32'h0000_0000);
    rdchk(ACCP_OFS_IRQ_STATUS, 32'h0000_0000);
    apb(1'b1, 8'h14, 32'hFFFF_FFFF);
    chk({31'h0, err}, 32'h0000_0001);
  endtask : t_irq

  // reset in mid-run while cores are powered
  task t_rereset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk({29'h0, pwr}, 32'h0000_0000);
    rdchk(ACCP_OFS_POWER_READY, 32'h0000_0000);
    rdchk(ACCP_OFS_CALIBRATION, 32'h0000_0000);
  endtask : t_rereset

  // ----------------------------------------------------------------
  // watchdog and main sequence
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      close_out();
    end
  end

  initial begin
    presetn  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 8'h00;
    pwdata   = 32'h0000_0000;
    n_errors = 0;
    n_tests  = 0;
    cyc      = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_power();
    t_cal_start();
    t_powerup_cal();
    t_lock();
    t_irq();
    t_rereset();
    close_out();
  end
endmodule : tb
`default_nettype wire
